// ### dv/hsw_det_model.sv
// behavioural analog detector facing the headset switch bank
`timescale 1ns/100ps
module hsw_det_model #(
  parameter int DELAY = 6
) (
  input  wire logic       i_clock,
  input  wire logic       i_start,
  input  wire logic [8:0] i_profile,
  output      logic       o_done,
  output      logic [8:0] o_result
);
  int cnt = 0;
  // ----------------------------------------------------------------
  // answer each start once, after a fixed measuring time
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    if (i_start) begin
      cnt <= DELAY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_done <= 1'b1;
    end
  end
  // result valid only with done; garbage otherwise
  assign o_result = o_done ? i_profile : ~i_profile;
endmodule

// ### dv/hsw_regs_sva.sv
// port assertions for the headset switch register bank
`timescale 1ns/100ps
`include "hsw_consts.svh"
module hsw_regs_sva (
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_detect_start,
  input wire logic       o_neg_to_band_a_sw,
  input wire logic       o_neg_to_sleeve_sw,
  input wire logic       o_pos_to_band_a_sw,
  input wire logic       o_pos_to_sleeve_sw,
  input wire logic       o_ground_fet_a,
  input wire logic       o_ground_fet_b,
  input wire logic       o_mic_present_n_out,
  input wire logic       o_mic_present_n_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire [5:0] sw = {o_neg_to_band_a_sw, o_neg_to_sleeve_sw, o_pos_to_band_a_sw,
                   o_pos_to_sleeve_sw, o_ground_fet_a, o_ground_fet_b};
  wire       pwr = i_wr_en && i_addr == 8'h02;
  function automatic logic [5:0] preset(input logic [2:0] m);
    case (m)
      3'h2: return 6'h26;
      3'h3: return 6'h19;
      3'h4: return 6'h24;
      3'h5: return 6'h18;
      3'h6: return 6'h33;
      default: return 6'h00;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // gap-enabled writes excluded: their timing depends on the prior set
  chk_preset_map: assert property (pwr && !i_wdata[3] &&
    i_wdata[2:0] != 3'h1 && i_wdata[2:0] != 3'h7 |->
    ##2 sw == preset(i_wdata[2:0])) else $error("preset switch set wrong");
  chk_start_lat: assert property (
    i_wr_en && i_addr == 8'h04 && i_wdata[0] |-> ##2 o_detect_start)
    else $error("detect start pulse missing");
  chk_start_once: assert property (
    o_detect_start |=> !o_detect_start) else $error("start pulse too long");
  chk_rev_read: assert property (
    i_rd_en && i_addr == 8'h01 |=> o_rdata == `HSW_REVISION_CODE_VALUE)
    else $error("revision code wrong");
  chk_unmapped_rd: assert property (
    i_rd_en && (i_addr == 8'h00 || i_addr > 8'h07) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !i_rd_en |=> $stable(o_rdata)) else $error("read data moved");
  chk_mic_force: assert property (
    i_wr_en && i_addr == 8'h04 && i_wdata[4] |=> !o_mic_present_n_oe_n)
    else $error("mic pin not forced low");
  chk_mic_level: assert property (
    !o_mic_present_n_out) else $error("mic pin drives high");
  cover property (pwr ##2 sw == 6'h33);
  cover property (o_detect_start);
  cover property (i_rd_en && i_addr == 8'h06);
endmodule

// ### dv/hsw_regs_tb_top.sv
// testbench top for the headset switch register bank
`timescale 1ns/100ps
`include "hsw_consts.svh"
module hsw_regs_tb_top;
  logic       i_clock = 1'b0;
  logic       i_nrst = 1'b0;
  logic       i_wr_en = 1'b0;
  logic       i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_ext_trigger = 1'b0;
  logic [8:0] profile = 9'h000;
  logic [8:0] res;
  logic [7:0] o_rdata;
  logic       done, start, nr, ns, pr, ps, fa, fb, mic_out, mic_oe_n;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         starts = 0;
  int         s;
  logic [5:0] pre [7] = '{6'h00, 6'h00, 6'h26, 6'h19, 6'h24, 6'h18, 6'h33};
  wire  [5:0] sw = {nr, ns, pr, ps, fa, fb};
  // pull-up on the open-drain mic pin
  wire        mic_pin_n = mic_oe_n ? 1'b1 : mic_out;
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) if (start === 1'b1) starts <= starts + 1;
  hsw_regs dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_ext_trigger(i_ext_trigger), .o_detect_start(start),
    .i_detect_done(done), .i_ground_on_sleeve(res[8]),
    .i_tip_sleeve_imp(res[7:5]), .i_tip_band_a_imp(res[4:2]),
    .i_three_contact(res[1]), .i_mic_found(res[0]),
    .o_neg_to_band_a_sw(nr), .o_neg_to_sleeve_sw(ns), .o_pos_to_band_a_sw(pr),
    .o_pos_to_sleeve_sw(ps), .o_ground_fet_a(fa), .o_ground_fet_b(fb),
    .o_mic_present_n_out(mic_out), .o_mic_present_n_oe_n(mic_oe_n));
  hsw_det_model det_u (.i_clock(i_clock), .i_start(start),
    .i_profile(profile), .o_done(done), .o_result(res));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_clock);
    i_rd_en <= 1'b0;
    wt(1);
    chk(n, e, o_rdata);
  endtask
  // start via the control bit, expect exactly one start pulse
  task automatic det(input logic [7:0] c, input logic [8:0] p);
    profile = p;
    s = starts;
    wr(8'h04, c);
    wt(20);
    chk("starts", 8'(s + 1), 8'(starts));
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    wr(8'h01, 8'h00);
    wr(8'h05, 8'hff);
    wr(8'h06, 8'hff);
    for (int a = 0; a < 9; a++) begin
      rc("reg", a[7:0], a == 1 ? `HSW_REVISION_CODE_VALUE : 8'h00);
    end
    chk("sw", 8'h00, {2'b00, sw});
    $display("test reset done");
    for (int m = 0; m < 7; m++) begin
      if (m != 1) begin
        wr(8'h02, m[7:0]);
        wt(2);
        chk("sw", {2'b00, pre[m]}, {2'b00, sw});
        rc("mode", 8'h02, m[7:0]);
      end
    end
    wr(8'h03, 8'hf3);
    wt(2);
    chk("sw", 8'h33, {2'b00, sw});
    wr(8'h02, 8'h07);
    wt(2);
    chk("sw", 8'h3f, {2'b00, sw});
    wr(8'h03, 8'ha2);
    wt(2);
    chk("sw", 8'h2a, {2'b00, sw});
    $display("test switch map done");
    det(8'h01, 9'h056);
    rc("detection_control", 8'h04, 8'h00);
    rc("event", 8'h06, 8'h01);
    rc("result", 8'h05, 8'h15);
    rc("mode", 8'h02, 8'h06);
    chk("sw", 8'h33, {2'b00, sw});
    rc("event", 8'h06, 8'h00);
    det(8'h03, 9'h1e1);
    rc("detection_control", 8'h04, 8'h02);
    rc("event", 8'h06, 8'h02);
    rc("result", 8'h05, 8'h78);
    rc("mode", 8'h02, 8'h00);
    chk("mic", 8'h00, {7'b0, mic_pin_n});
    wr(8'h07, 8'h08);
    det(8'h07, 9'h000);
    chk("mic", 8'h01, {7'b0, mic_pin_n});
    wr(8'h07, 8'h00);
    wt(2);
    chk("mic", 8'h00, {7'b0, mic_pin_n});
    wr(8'h07, 8'h10);
    wt(2);
    chk("mic", 8'h01, {7'b0, mic_pin_n});
    rc("mask", 8'h07, 8'h10);
    rc("event", 8'h06, 8'h08);
    $display("test detection done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, k ? 8'h00 : 8'h08);
      s = starts;
      @(posedge i_clock) i_ext_trigger <= 1'b1;
      wt(8);
      @(posedge i_clock) i_ext_trigger <= 1'b0;
      wt(20);
      chk("ext", 8'(s + k), 8'(starts));
    end
    chk("mic", 8'h01, {7'b0, mic_pin_n});
    wr(8'h04, 8'h10);
    wt(1);
    chk("mic", 8'h00, {7'b0, mic_pin_n});
    $display("test trigger done");
    wr(8'h02, 8'h0a);
    wt(25);
    chk("sw", 8'h26, {2'b00, sw});
    wr(8'h02, 8'h0b);
    wt(2);
    chk("sw", 8'h00, {2'b00, sw});
    wt(25);
    chk("sw", 8'h19, {2'b00, sw});
    $display("test break before make done");
    final_report();
  end
endmodule
bind hsw_regs hsw_regs_sva chk_u (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_detect_start(o_detect_start),
  .o_neg_to_band_a_sw(o_neg_to_band_a_sw),
  .o_neg_to_sleeve_sw(o_neg_to_sleeve_sw),
  .o_pos_to_band_a_sw(o_pos_to_band_a_sw),
  .o_pos_to_sleeve_sw(o_pos_to_sleeve_sw),
  .o_ground_fet_a(o_ground_fet_a), .o_ground_fet_b(o_ground_fet_b),
  .o_mic_present_n_out(o_mic_present_n_out),
  .o_mic_present_n_oe_n(o_mic_present_n_oe_n));

// ### rtl/hsw_consts.svh
// offsets, fields, reset values and timing counts of the headset switch
`ifndef HSW_CONSTS_SVH
`define HSW_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HSW_REVISION_CODE_ADDR         8'h01
`define HSW_SWITCH_CONFIG_ADDR         8'h02
`define HSW_MANUAL_SWITCH_ENABLES_ADDR 8'h03
`define HSW_DETECTION_CONTROL_ADDR     8'h04
`define HSW_DETECTION_RESULT_ADDR      8'h05
`define HSW_EVENT_STATUS_ADDR          8'h06
`define HSW_EVENT_MASK_ADDR            8'h07

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HSW_REG_RESET                  8'h00
// arbitrary neutral value
`define HSW_REVISION_CODE_VALUE        8'h5a

// ----------------------------------------------------------------
// switch_config fields
// ----------------------------------------------------------------
`define HSW_MODE_MSB                   2
`define HSW_BREAK_BEFORE_MAKE_EN_BIT   3
`define HSW_MODE_ISOLATE               3'h0
`define HSW_MODE_RESERVED              3'h1
`define HSW_MODE_NORM_SE               3'h2
`define HSW_MODE_REV_SE                3'h3
`define HSW_MODE_NORM_DIFF             3'h4
`define HSW_MODE_REV_DIFF              3'h5
`define HSW_MODE_THREE_CONTACT         3'h6
`define HSW_MODE_MANUAL                3'h7

// ----------------------------------------------------------------
// manual_switch_enables fields
// ----------------------------------------------------------------
`define HSW_NEG_TO_BAND_A_BIT           7
`define HSW_NEG_TO_SLEEVE_BIT          6
`define HSW_POS_TO_BAND_A_BIT           5
`define HSW_POS_TO_SLEEVE_BIT          4
`define HSW_GROUND_FET_A_BIT           1
`define HSW_GROUND_FET_B_BIT           0

// ----------------------------------------------------------------
// detection_control fields
// ----------------------------------------------------------------
`define HSW_MIC_MANUAL_LOW_BIT         4
`define HSW_EXT_TRIGGER_DISABLE_BIT    3
`define HSW_MIC_AS_INT_BIT             2
`define HSW_AUTO_SWITCH_DISABLE_BIT    1
`define HSW_DETECT_START_BIT           0

// ----------------------------------------------------------------
// detection_result and event fields
// ----------------------------------------------------------------
`define HSW_GROUND_BAND_LOC_BIT        6
`define HSW_TIP_SLEEVE_IMP_LSB         3
`define HSW_TIP_BAND_A_IMP_LSB          0
`define HSW_DETECT_FAIL_BIT            3
`define HSW_MIC_FOUND_BIT              1
`define HSW_THREE_CONTACT_BIT          0
`define HSW_MIC_PIN_DISABLE_BIT        4

// ----------------------------------------------------------------
// break-before-make gap
// ----------------------------------------------------------------
`define HSW_CLOCK_MHZ                  200
`define HSW_GAP_NS                     100
// rounded up so the open gap never falls short of the time
`define HSW_GAP_CYCLES ((`HSW_GAP_NS * `HSW_CLOCK_MHZ + 999) / 1000)

`endif

// ### rtl/hsw_pkg.sv
// types of the headset switch register bank
package hsw_pkg;

  // order: neg_band_a, neg_sleeve, pos_band_a, pos_sleeve, fet_a, fet_b
  typedef logic [5:0] hsw_switch_t;

  typedef struct packed {
    logic [3:0]  switch_config;
    logic [7:0]  manual_switch_enables;
    logic [4:0]  detection_control;
    logic [6:0]  detection_result;
    logic [3:0]  event_status;
    logic [7:0]  event_mask;
    logic        mic_found;
    logic        trigger_prev;
    logic        detect_start;
    hsw_switch_t switch_state;
    logic [7:0]  gap_count;
    logic [7:0]  rdata;
  } hsw_state_t;

endpackage

// ### rtl/hsw_regs.sv
// control and status register bank of the headset switch
// Function
// - configuration code bits 2:0; 000 opens all switches; 001 reserved
// - code 010 closes ground fet a, neg-to-band_a and pos-to-sleeve
// - code 011 closes ground fet b, neg-to-sleeve and pos-to-band_a
// - code 100 closes only neg-to-band_a and pos-to-sleeve
// - code 101 closes only neg-to-sleeve and pos-to-band_a
// - code 110 closes both fets, neg-to-sleeve and neg-to-band_a
// - code 111 is manual: switches follow their individual enable bits
// - switch_config bit 3 enables break-before-make sequencing
// - manual bits 7..4 close neg-band_a, neg-sleeve, pos-band_a, pos-sleeve
// - manual bits 1 and 0 close ground fet a and b
// - control bit 4 forces the mic-present pin low
// - control bit 3 makes the external trigger pin ignored
// - control bit 2 turns the mic-present pin into an interrupt
// - control bit 1 stops automatic switching after detection
// - writing 1 to control bit 0 starts a detection
// - result bit 6 gives ground band: 1 sleeve, 0 band_a
// - result bits 5:3 hold tip-to-sleeve impedance code
// - result bits 2:0 hold tip-to-band_a impedance code
// - event bit 3 set when detection recognises no plug
// - event bit 1 set when a microphone is found
// - event bit 0 set when a three-contact plug is found
// - masked detection failure never raises the interrupt
// - with auto switching disabled the code is forced to 000 after detection
// - writes to read-only registers are accepted and change nothing
`timescale 1ns/100ps
`include "hsw_consts.svh"

module hsw_regs
  import hsw_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output      logic [7:0] o_rdata,
  input  wire logic       i_ext_trigger,
  output      logic       o_detect_start,
  input  wire logic       i_detect_done,
  input  wire logic       i_ground_on_sleeve,
  input  wire logic [2:0] i_tip_sleeve_imp,
  input  wire logic [2:0] i_tip_band_a_imp,
  input  wire logic       i_three_contact,
  input  wire logic       i_mic_found,
  output      logic       o_neg_to_band_a_sw,
  output      logic       o_neg_to_sleeve_sw,
  output      logic       o_pos_to_band_a_sw,
  output      logic       o_pos_to_sleeve_sw,
  output      logic       o_ground_fet_a,
  output      logic       o_ground_fet_b,
  output      logic       o_mic_present_n_out,
  output      logic       o_mic_present_n_oe_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic hsw_switch_t decode_mode(input logic [2:0] mode,
                                              input logic [7:0] man);
    hsw_switch_t sw;
    sw = '0;
    unique case (mode)
      `HSW_MODE_NORM_SE:       sw = 6'b100110;
      `HSW_MODE_REV_SE:        sw = 6'b011001;
      `HSW_MODE_NORM_DIFF:     sw = 6'b100100;
      `HSW_MODE_REV_DIFF:      sw = 6'b011000;
      `HSW_MODE_THREE_CONTACT: sw = 6'b110011;
      `HSW_MODE_MANUAL:        sw = {man[`HSW_NEG_TO_BAND_A_BIT],
                                     man[`HSW_NEG_TO_SLEEVE_BIT],
                                     man[`HSW_POS_TO_BAND_A_BIT],
                                     man[`HSW_POS_TO_SLEEVE_BIT],
                                     man[`HSW_GROUND_FET_A_BIT],
                                     man[`HSW_GROUND_FET_B_BIT]};
      `HSW_MODE_ISOLATE,
      `HSW_MODE_RESERVED:      sw = '0;
    endcase
    return sw;
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hsw_state_t  state;
  hsw_state_t  next_state;
  hsw_switch_t target;
  logic        ext_start;
  logic        int_pending;
  logic [7:0]  ctrl_ext;

  always_comb begin
    next_state = state;
    next_state.detect_start = 1'b0;
    next_state.trigger_prev = i_ext_trigger;
    ctrl_ext = {3'h0, state.detection_control};

    // rising edge of the trigger pin, unless disabled
    ext_start = i_ext_trigger && !state.trigger_prev &&
                !state.detection_control[`HSW_EXT_TRIGGER_DISABLE_BIT];

    // software start bit self-clears on the same edge that raises the start pulse
    if (state.detection_control[`HSW_DETECT_START_BIT] || ext_start) begin
      next_state.detect_start = 1'b1;
      next_state.detection_control[`HSW_DETECT_START_BIT] = 1'b0;
    end

    // reads; event status clears on read, new events below win
    if (i_rd_en) begin
      unique case (i_addr)
        `HSW_REVISION_CODE_ADDR:
          next_state.rdata = `HSW_REVISION_CODE_VALUE;
        `HSW_SWITCH_CONFIG_ADDR:    next_state.rdata = {4'h0,
                                                        state.switch_config};
        `HSW_MANUAL_SWITCH_ENABLES_ADDR:
          next_state.rdata = state.manual_switch_enables & 8'hf3;
        `HSW_DETECTION_CONTROL_ADDR: next_state.rdata = ctrl_ext;
        `HSW_DETECTION_RESULT_ADDR: next_state.rdata = {1'b0,
                                                        state.detection_result};
        `HSW_EVENT_STATUS_ADDR: begin
          next_state.rdata = {4'h0, state.event_status};
          next_state.event_status = 4'h0;
        end
        `HSW_EVENT_MASK_ADDR:       next_state.rdata = state.event_mask & 8'h1b;
        default:                    next_state.rdata = 8'h00;
      endcase
    end

    // writes; read-only offsets take the byte and keep their contents
    if (i_wr_en) begin
      unique case (i_addr)
        `HSW_SWITCH_CONFIG_ADDR:
          next_state.switch_config = i_wdata[3:0];
        `HSW_MANUAL_SWITCH_ENABLES_ADDR:
          next_state.manual_switch_enables = i_wdata & 8'hf3;
        `HSW_DETECTION_CONTROL_ADDR:
          next_state.detection_control = i_wdata[4:0];
        `HSW_EVENT_MASK_ADDR:
          next_state.event_mask = i_wdata & 8'h1b;
        default: ;
      endcase
    end

    // detection outcome
    if (i_detect_done) begin
      next_state.detection_result = {i_ground_on_sleeve,
                                     i_tip_sleeve_imp,
                                     i_tip_band_a_imp};
      next_state.mic_found = i_mic_found && !i_three_contact;
      if (i_three_contact) begin
        next_state.event_status[`HSW_THREE_CONTACT_BIT] = 1'b1;
      end else if (i_mic_found) begin
        next_state.event_status[`HSW_MIC_FOUND_BIT] = 1'b1;
      end else begin
        next_state.event_status[`HSW_DETECT_FAIL_BIT] = 1'b1;
      end
      if (state.detection_control[`HSW_AUTO_SWITCH_DISABLE_BIT]) begin
        next_state.switch_config[`HSW_MODE_MSB:0] =
          `HSW_MODE_ISOLATE;
      end else if (i_three_contact) begin
        next_state.switch_config[`HSW_MODE_MSB:0] = `HSW_MODE_THREE_CONTACT;
      end else if (i_mic_found) begin
        next_state.switch_config[`HSW_MODE_MSB:0] =
          i_ground_on_sleeve ? `HSW_MODE_REV_SE : `HSW_MODE_NORM_SE;
      end else begin
        next_state.switch_config[`HSW_MODE_MSB:0] = `HSW_MODE_ISOLATE;
      end
    end

    // break-before-make: open everything for a gap, then close new set
    target = decode_mode(state.switch_config[`HSW_MODE_MSB:0],
                         state.manual_switch_enables);
    if (state.gap_count != 8'h00) begin
      next_state.gap_count = state.gap_count - 8'h01;
      next_state.switch_state = '0;
    end else if (state.switch_state != target) begin
      if (state.switch_config[`HSW_BREAK_BEFORE_MAKE_EN_BIT] &&
          state.switch_state != '0) begin
        next_state.switch_state = '0;
        next_state.gap_count = 8'(`HSW_GAP_CYCLES - 1);
      end else begin
        next_state.switch_state = target;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // masked events never drive the pin
  assign int_pending = |(state.event_status & ~state.event_mask[3:0]);

  always_comb begin
    logic pull_low;
    pull_low = 1'b0;
    if (state.detection_control[`HSW_MIC_MANUAL_LOW_BIT]) begin
      pull_low = 1'b1;
    end else if (state.detection_control[`HSW_MIC_AS_INT_BIT]) begin
      pull_low = int_pending &&
                 !state.event_mask[`HSW_MIC_PIN_DISABLE_BIT];
    end else begin
      pull_low = state.mic_found;
    end
    o_mic_present_n_oe_n = !pull_low;
  end

  assign o_mic_present_n_out = 1'b0;
  assign o_rdata             = state.rdata;
  assign o_detect_start      = state.detect_start;
  assign o_neg_to_band_a_sw   = state.switch_state[5];
  assign o_neg_to_sleeve_sw  = state.switch_state[4];
  assign o_pos_to_band_a_sw   = state.switch_state[3];
  assign o_pos_to_sleeve_sw  = state.switch_state[2];
  assign o_ground_fet_a      = state.switch_state[1];
  assign o_ground_fet_b      = state.switch_state[0];

endmodule
